// ===== logic/boundary_scan_tap.v
// Boundary-scan test access port: TAP controller, instruction and data registers
//
// Contract
// R1 - Power-up sits in test-logic-reset; IDCODE current; system logic runs normally.
// R2 - Select-DR-scan: low to capture-DR, high to select-IR-scan; registers hold.
// R3 - Capture-DR loads selected register if loadable; low to shift-DR, high exit1-DR.
// R4 - Shift-DR shifts selected register from data in toward data out.
// R5 - Exit1-DR: high to update-DR, low to pause-DR.
// R6 - Pause-DR halts shifting; stays on low, high to exit2-DR.
// R7 - Exit2-DR: high to update-DR, low back to shift-DR.
// R8 - Falling edge in update-DR copies shift paths into output latches.
// R9 - Select-IR-scan: low to capture-IR, high to test-logic-reset.
// R10 - Capture-IR loads fixed value; high to exit1-IR, low to shift-IR.
// R11 - Shift-IR shifts instruction while low; high to exit1-IR; others hold.
// R12 - Exit1/exit2-IR high to update-IR; low to pause-IR or shift-IR.
// R13 - Pause-IR holds; stays on low, high to exit2-IR.
// R14 - Update-IR falling edge latches instruction; low to idle, high select-DR.
// R15 - Instruction register is 3-bit shift stage plus 3-bit latch.
// R16 - 010 sample/preload, 000 extest select boundary; 111 bypass.
// R17 - Clamp 011 drives boundary outputs, bypass path; high-Z 100, IDCODE 001.
// R18 - Sample captures pin states without disturbing operation; shifts serial data.
// R19 - Bypass routes data through one-bit register; function untouched.
// R20 - Extest drives outputs from boundary latches; boundary path; captures inputs.
// R21 - High-Z floats all outputs; bypass register in path.
// R22 - IDCODE loads 32-bit ID in capture-DR, LSB 1, maker, part, version.
// R23 - Reset stays on high, low to idle; idle stays low, high select-DR.
// R24 - Test reset low forces reset state; five high edges reach it.
// R25 - Capture-IR value ends in 01; data out driven only in shift states.
`default_nettype none
`include "tap_consts.vh"
module boundary_scan_tap (
  // Core clock and reset
  input  wire                  CORE_CLK,
  input  wire                  RESET,
  // Tester pins
  input  wire                  TEST_CLOCK,
  input  wire                  TEST_MODE_SELECT,
  input  wire                  TEST_DATA_IN,
  input  wire                  TEST_RESET_N,
  output reg                   TEST_DATA_OUT,
  output wire                  TEST_DATA_OUT_OE_N,
  // System pins seen by the boundary register
  input  wire [`BSR_WIDTH-1:0] SYS_PIN_IN,
  input  wire [`BSR_WIDTH-1:0] SYS_OUT_FUNC,
  output reg  [`BSR_WIDTH-1:0] SYS_OUT,
  output reg                   SYS_OUT_FLOAT
);
  // One-hot TAP states
  localparam [15:0] ST_RESET   = 16'h0001;
  localparam [15:0] ST_IDLE    = 16'h0002;
  localparam [15:0] ST_SEL_DR  = 16'h0004;
  localparam [15:0] ST_CAP_DR  = 16'h0008;
  localparam [15:0] ST_SH_DR   = 16'h0010;
  localparam [15:0] ST_EX1_DR  = 16'h0020;
  localparam [15:0] ST_PAU_DR  = 16'h0040;
  localparam [15:0] ST_EX2_DR  = 16'h0080;
  localparam [15:0] ST_UPD_DR  = 16'h0100;
  localparam [15:0] ST_SEL_IR  = 16'h0200;
  localparam [15:0] ST_CAP_IR  = 16'h0400;
  localparam [15:0] ST_SH_IR   = 16'h0800;
  localparam [15:0] ST_EX1_IR  = 16'h1000;
  localparam [15:0] ST_PAU_IR  = 16'h2000;
  localparam [15:0] ST_EX2_IR  = 16'h4000;
  localparam [15:0] ST_UPD_IR  = 16'h8000;

  // Pin synchronisers, two flops each
  reg  [1:0] clk_sync_reg;
  reg  [1:0] tms_sync_reg;
  reg  [1:0] tdi_sync_reg;
  reg  [1:0] trst_sync_reg;
  reg        clk_prev_reg;
  wire       tck_rise;
  wire       tck_fall;
  wire       tms;
  wire       tdi;
  wire       trst_active;

  // Controller and registers
  reg  [15:0]           state_reg;
  reg  [15:0]           state_next;
  reg  [`IR_WIDTH-1:0]  ir_shift_reg;
  reg  [`IR_WIDTH-1:0]  ir_reg;
  reg                   bypass_reg;
  reg  [`ID_WIDTH-1:0]  id_shift_reg;
  wire                  bsr_sel;
  wire                  id_sel;
  wire                  bsr_serial;
  wire [`BSR_WIDTH-1:0] bsr_latch;
  reg  [`BSR_WIDTH-1:0] pin_meta_reg;
  reg  [`BSR_WIDTH-1:0] pin_sync_reg;
  wire [`ID_WIDTH-1:0]  id_code;
  wire                  drives_outputs;
  reg                   serial_bit;

  // Decide which data register an instruction selects
  function [1:0] dr_select;
    input [`IR_WIDTH-1:0] ins;
    begin
      case (ins)
        `INS_EXTEST: dr_select = 2'h1;
        `INS_SAMPLE: dr_select = 2'h1;
        `INS_IDCODE: dr_select = 2'h2;
        default:     dr_select = 2'h0;
      endcase
    end
  endfunction

  // Sample tester and system pins into the core clock domain
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      clk_sync_reg  <= `SYNC_RESET;
      tms_sync_reg  <= `SYNC_RESET;
      tdi_sync_reg  <= `SYNC_RESET;
      trst_sync_reg <= `SYNC_RESET;
      clk_prev_reg  <= 1'b0;
    end else begin
      clk_sync_reg  <= {clk_sync_reg[0], TEST_CLOCK};
      tms_sync_reg  <= {tms_sync_reg[0], TEST_MODE_SELECT};
      tdi_sync_reg  <= {tdi_sync_reg[0], TEST_DATA_IN};
      trst_sync_reg <= {trst_sync_reg[0], TEST_RESET_N};
      clk_prev_reg  <= clk_sync_reg[1];
      pin_meta_reg  <= SYS_PIN_IN;        // System pins, first flop
      pin_sync_reg  <= pin_meta_reg;      // Only this flop feeds the boundary register
    end
  end

  // Edge strobes of the test clock
  assign tck_rise    = clk_sync_reg[1] & ~clk_prev_reg;
  assign tck_fall    = ~clk_sync_reg[1] & clk_prev_reg;
  assign tms         = tms_sync_reg[1];
  assign tdi         = tdi_sync_reg[1];
  assign trst_active = ~trst_sync_reg[1];

  // Next-state decode on mode select
  always @* begin
    case (state_reg)
      ST_RESET: begin
        if (tms) begin
          state_next = ST_RESET;                            // R23
        end else begin
          state_next = ST_IDLE;                             // R23
        end
      end
      ST_IDLE: begin
        if (tms) begin
          state_next = ST_SEL_DR;                           // R23
        end else begin
          state_next = ST_IDLE;                             // R23
        end
      end
      ST_SEL_DR: begin
        if (tms) begin
          state_next = ST_SEL_IR;                           // R2
        end else begin
          state_next = ST_CAP_DR;                           // R2
        end
      end
      ST_CAP_DR: begin
        if (tms) begin
          state_next = ST_EX1_DR;                           // R3
        end else begin
          state_next = ST_SH_DR;                            // R3
        end
      end
      ST_SH_DR: begin
        if (tms) begin
          state_next = ST_EX1_DR;                           // R4
        end else begin
          state_next = ST_SH_DR;                            // R4
        end
      end
      ST_EX1_DR: begin
        if (tms) begin
          state_next = ST_UPD_DR;                           // R5
        end else begin
          state_next = ST_PAU_DR;                           // R5
        end
      end
      ST_PAU_DR: begin
        if (tms) begin
          state_next = ST_EX2_DR;                           // R6
        end else begin
          state_next = ST_PAU_DR;                           // R6
        end
      end
      ST_EX2_DR: begin
        if (tms) begin
          state_next = ST_UPD_DR;                           // R7
        end else begin
          state_next = ST_SH_DR;                            // R7
        end
      end
      ST_UPD_DR: begin
        if (tms) begin
          state_next = ST_SEL_DR;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_SEL_IR: begin
        if (tms) begin
          state_next = ST_RESET;                            // R9
        end else begin
          state_next = ST_CAP_IR;                           // R9
        end
      end
      ST_CAP_IR: begin
        if (tms) begin
          state_next = ST_EX1_IR;                           // R10
        end else begin
          state_next = ST_SH_IR;                            // R10
        end
      end
      ST_SH_IR: begin
        if (tms) begin
          state_next = ST_EX1_IR;                           // R11
        end else begin
          state_next = ST_SH_IR;                            // R11
        end
      end
      ST_EX1_IR: begin
        if (tms) begin
          state_next = ST_UPD_IR;                           // R12
        end else begin
          state_next = ST_PAU_IR;                           // R12
        end
      end
      ST_PAU_IR: begin
        if (tms) begin
          state_next = ST_EX2_IR;                           // R13
        end else begin
          state_next = ST_PAU_IR;                           // R13
        end
      end
      ST_EX2_IR: begin
        if (tms) begin
          state_next = ST_UPD_IR;                           // R12
        end else begin
          state_next = ST_SH_IR;                            // R12
        end
      end
      ST_UPD_IR: begin
        if (tms) begin
          state_next = ST_SEL_DR;                           // R14
        end else begin
          state_next = ST_IDLE;                             // R14
        end
      end
      default:   state_next = ST_RESET;
    endcase
  end

  // Controller steps on each rising test clock edge
  always @(posedge CORE_CLK) begin
    if (RESET || trst_active) begin
      state_reg <= ST_RESET;                                // R1 R24
    end else if (tck_rise) begin
      state_reg <= state_next;                              // R24
    end
  end

  // Instruction shift stage: fixed capture, shift toward bit 0
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      ir_shift_reg <= `IR_CAPTURE;
    end else if (tck_rise && state_reg == ST_CAP_IR) begin
      ir_shift_reg <= `IR_CAPTURE;                          // R10 R25
    end else if (tck_rise && state_reg == ST_SH_IR) begin
      ir_shift_reg <= {tdi, ir_shift_reg[`IR_WIDTH-1:1]};   // R11 R15
    end
  end

  // Current instruction: IDCODE in reset, latched on falling edge in update-IR
  always @(posedge CORE_CLK) begin
    if (RESET || trst_active || state_reg == ST_RESET) begin
      ir_reg <= `INS_IDCODE;                                // R1
    end else if (tck_fall && state_reg == ST_UPD_IR) begin
      ir_reg <= ir_shift_reg;                               // R14 R15
    end
  end

  assign bsr_sel = (dr_select(ir_reg) == 2'h1);             // R16
  assign id_sel  = (dr_select(ir_reg) == 2'h2);             // R17 R22

  // Bypass: captures zero, one-bit shift path
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      bypass_reg <= 1'b0;
    end else if (tck_rise && !bsr_sel && !id_sel) begin
      if (state_reg == ST_CAP_DR) begin
        bypass_reg <= 1'b0;
      end else if (state_reg == ST_SH_DR) begin
        bypass_reg <= tdi;                                  // R19 R21
      end
    end
  end

  // Identification code, fixed layout
  assign id_code = {`ID_VERSION, `ID_PART, `ID_MAKER, `ID_MARKER};

  // Identification shift path
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      id_shift_reg <= {`ID_WIDTH{1'b0}};
    end else if (tck_rise && id_sel) begin
      if (state_reg == ST_CAP_DR) begin
        id_shift_reg <= id_code;                            // R22
      end else if (state_reg == ST_SH_DR) begin
        id_shift_reg <= {tdi, id_shift_reg[`ID_WIDTH-1:1]}; // R22
      end
    end
  end

  // Boundary register: capture pins, shift, latch in update-DR
  scan_shift_reg #(
    .WIDTH (`BSR_WIDTH)
  ) u_bsr (
    .clk          (CORE_CLK),
    .rst          (RESET),
    .capture      (tck_rise && bsr_sel && state_reg == ST_CAP_DR), // R3 R18 R20
    .shift        (tck_rise && bsr_sel && state_reg == ST_SH_DR),  // R4 R18
    .update       (tck_fall && bsr_sel && state_reg == ST_UPD_DR), // R8
    .serial_in    (tdi),
    .capture_data (pin_sync_reg),
    .serial_out   (bsr_serial),
    .parallel_out (bsr_latch)
  );

  // Serial output source by state and instruction
  always @* begin
    if (state_reg == ST_SH_IR) begin
      serial_bit = ir_shift_reg[0];
    end else if (bsr_sel) begin
      serial_bit = bsr_serial;
    end else if (id_sel) begin
      serial_bit = id_shift_reg[0];
    end else begin
      serial_bit = bypass_reg;
    end
  end

  // Data out changes on the falling edge of the test clock
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      TEST_DATA_OUT <= 1'b0;
    end else if (tck_fall) begin
      TEST_DATA_OUT <= serial_bit;
    end
  end

  // Driven only in the two shift states, released otherwise
  assign TEST_DATA_OUT_OE_N = ~(state_reg == ST_SH_DR || state_reg == ST_SH_IR); // R25

  // Extest and clamp take outputs from the boundary latches
  assign drives_outputs = (ir_reg == `INS_EXTEST) || (ir_reg == `INS_CLAMP);

  // System output mux: normal function unless a test instruction owns the pins
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      SYS_OUT       <= {`BSR_WIDTH{1'b0}};
      SYS_OUT_FLOAT <= 1'b0;
    end else begin
      SYS_OUT       <= drives_outputs ? bsr_latch : SYS_OUT_FUNC; // R17 R20 R19
      SYS_OUT_FLOAT <= (ir_reg == `INS_HIGHZ);                    // R21
    end
  end
endmodule
`default_nettype wire

// ===== logic/tap_consts.vh
// Constants for the boundary-scan test access port
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH
// Instruction register
`define IR_WIDTH        3
`define IR_CAPTURE      3'h1
`define INS_EXTEST      3'h0
`define INS_IDCODE      3'h1
`define INS_SAMPLE      3'h2
`define INS_CLAMP       3'h3
`define INS_HIGHZ       3'h4
`define INS_BYPASS      3'h7
// Identification register layout (values arbitrary, not any real part)
`define ID_WIDTH        32
`define ID_VERSION      4'h0
`define ID_PART         16'h5A5A
`define ID_MAKER        11'h0F0
`define ID_MARKER       1'h1
// Boundary register length
`define BSR_WIDTH       8
// Tester reset sync, TAP state count
`define SYNC_RESET      2'h0
`define TAP_STATES      16
`endif

// ===== logic/scan_shift_reg.v
// Shift path with latched parallel output, used for the boundary register
`default_nettype none
module scan_shift_reg #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             capture,
  input  wire             shift,
  input  wire             update,
  input  wire             serial_in,
  input  wire [WIDTH-1:0] capture_data,
  output wire             serial_out,
  output reg  [WIDTH-1:0] parallel_out
);
  reg [WIDTH-1:0] shift_reg;

  assign serial_out = shift_reg[0];

  // Capture, shift toward bit 0, or hold
  always @(posedge clk) begin
    if (rst) begin
      shift_reg <= {WIDTH{1'b0}};
    end else if (capture) begin
      shift_reg <= capture_data;
    end else if (shift) begin
      shift_reg <= {serial_in, shift_reg[WIDTH-1:1]};
    end
  end

  // Output latch loads only on update, so shifting leaves it stable
  always @(posedge clk) begin
    if (rst) begin
      parallel_out <= {WIDTH{1'b0}};
    end else if (update) begin
      parallel_out <= shift_reg;
    end
  end
endmodule
`default_nettype wire

// ===== tb/boundary_scan_tap_checker.sv
// Port-level assertions for the boundary-scan test port
`default_nettype none
`include "tap_consts.vh"
module boundary_scan_tap_checker (
  // Clock, reset and tester pins
  input wire logic                  CORE_CLK,
  input wire logic                  RESET,
  input wire logic                  TEST_CLOCK,
  input wire logic                  TEST_RESET_N,
  input wire logic                  TEST_DATA_OUT,
  input wire logic                  TEST_DATA_OUT_OE_N,
  // System side
  input wire logic [`BSR_WIDTH-1:0] SYS_OUT_FUNC,
  input wire logic [`BSR_WIDTH-1:0] SYS_OUT,
  input wire logic                  SYS_OUT_FLOAT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);
  // Values at reset release, then outputs follow normal function
  a_rel_tdo_off: assert property ($fell(RESET) |-> TEST_DATA_OUT_OE_N && !TEST_DATA_OUT)
    else $error("data out active at reset release");
  a_rel_sys_normal: assert property ($fell(RESET) |-> (SYS_OUT == '0 && !SYS_OUT_FLOAT)
    ##1 SYS_OUT == $past(SYS_OUT_FUNC))
    else $error("system outputs wrong after reset");
  // Test reset pin forces the reset state
  a_trst_tdo_off: assert property ((!TEST_RESET_N)[*4] |=> TEST_DATA_OUT_OE_N)
    else $error("data out active in test reset");
  a_trst_idcode: assert property ((!TEST_RESET_N)[*6]
    |=> !SYS_OUT_FLOAT && SYS_OUT == $past(SYS_OUT_FUNC))
    else $error("system outputs disturbed in test reset");
  // Serial output and float timing against the test clock
  a_oe_on_rise: assert property ($fell(TEST_DATA_OUT_OE_N) |-> TEST_CLOCK && $past(TEST_CLOCK, 2))
    else $error("data out enabled away from rising edge");
  a_oe_off_rise: assert property ($rose(TEST_DATA_OUT_OE_N) && TEST_RESET_N
    && $past(TEST_RESET_N, 4) |-> TEST_CLOCK)
    else $error("data out released away from rising edge");
  a_tdo_on_fall: assert property ($changed(TEST_DATA_OUT) |-> !TEST_CLOCK && !$past(TEST_CLOCK, 2))
    else $error("data out moved away from falling edge");
  a_float_on_fall: assert property ($rose(SYS_OUT_FLOAT) |-> !TEST_CLOCK && !$past(TEST_CLOCK, 2))
    else $error("float set away from falling edge");
  // Main scenarios
  c_shift: cover property ($fell(TEST_DATA_OUT_OE_N));
  c_float: cover property ($rose(SYS_OUT_FLOAT));
  c_trst: cover property ((!TEST_RESET_N)[*6]);
endmodule
bind boundary_scan_tap boundary_scan_tap_checker chk (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .TEST_CLOCK(TEST_CLOCK), .TEST_RESET_N(TEST_RESET_N),
  .TEST_DATA_OUT(TEST_DATA_OUT), .TEST_DATA_OUT_OE_N(TEST_DATA_OUT_OE_N),
  .SYS_OUT_FUNC(SYS_OUT_FUNC), .SYS_OUT(SYS_OUT), .SYS_OUT_FLOAT(SYS_OUT_FLOAT));
`default_nettype wire

// ===== tb/tap_tester.sv
// Boundary-scan tester model driving the test port pins
`default_nettype none
module tap_tester (
  input  wire logic clk,
  input  wire logic tdo,
  input  wire logic oe_n,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  output var  logic trst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  // Pins idle with the test clock resting low
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end
  // One 80 ns test clock period; a released line reads back as a toggling level
  task automatic bit_cyc(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (8) @(negedge clk);
    q = oe_n ? ~last : tdo;
    last = q;
    tck = 1'b1;
    repeat (8) @(negedge clk);
    tck = 1'b0;
  endtask
  // Scan from run-test-idle, LSB first, optional pause after bit pz, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] d, input int pz,
                      output logic [31:0] q);
    logic x;
    q = '0;
    bit_cyc(1'b1, 1'b0, x);
    if (ir) bit_cyc(1'b1, 1'b0, x);
    bit_cyc(1'b0, 1'b0, x);
    bit_cyc(1'b0, 1'b0, x);
    for (int i = 0; i < n; i++) begin
      bit_cyc(i == n - 1 || i == pz, d[i], q[i]);
      if (i == pz) begin
        bit_cyc(1'b0, 1'b0, x);
        bit_cyc(1'b0, 1'b0, x);
        bit_cyc(1'b1, 1'b0, x);
        bit_cyc(1'b0, 1'b0, x);
      end
    end
    bit_cyc(1'b1, 1'b0, x);
    bit_cyc(1'b0, 1'b0, x);
  endtask
  // Test reset pulse while the test clock rests
  task automatic pulse_trst();
    trst_n = 1'b0;
    repeat (8) @(negedge clk);
    trst_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== tb/boundary_scan_tap_tb_top.sv
// Self-checking bench for the boundary-scan test port
`default_nettype none
`include "tap_consts.vh"
module boundary_scan_tap_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  PINS = 8'h6B;
  localparam logic [7:0]  FUNC = 8'h81;
  localparam logic [31:0] IDV  = {`ID_VERSION, `ID_PART, `ID_MAKER, `ID_MARKER};
  typedef struct {logic [2:0] code; int n; logic [31:0] pat, dout; logic [7:0] sys; logic flt;} row_t;
  // Instruction, scan length, data in, data out, system outputs, float
  row_t rows [6] = '{
    '{`INS_SAMPLE, 8, 32'hA5, 32'h6B, FUNC, 1'b0},
    '{`INS_EXTEST, 8, 32'h3C, 32'h6B, 8'h3C, 1'b0},
    '{`INS_CLAMP, 8, 32'h96, 32'h2C, 8'h3C, 1'b0},
    '{`INS_HIGHZ, 8, 32'h96, 32'h2C, FUNC, 1'b1},
    '{`INS_BYPASS, 8, 32'h96, 32'h2C, FUNC, 1'b0},
    '{`INS_IDCODE, 32, 32'h0, IDV, FUNC, 1'b0}
  };
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  wire logic       tck, tms, tdi, trst_n, tdo, oe_n, flt;
  wire logic [7:0] sout;
  int              n_mismatch = 0;
  int              samples_checked = 0;
  boundary_scan_tap dut (
    .CORE_CLK(clk), .RESET(rst), .TEST_CLOCK(tck), .TEST_MODE_SELECT(tms),
    .TEST_DATA_IN(tdi), .TEST_RESET_N(trst_n), .TEST_DATA_OUT(tdo),
    .TEST_DATA_OUT_OE_N(oe_n), .SYS_PIN_IN(PINS), .SYS_OUT_FUNC(FUNC),
    .SYS_OUT(sout), .SYS_OUT_FLOAT(flt));
  tap_tester tst (
    .clk(clk), .tdo(tdo), .oe_n(oe_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));
  // 200 MHz core clock
  always #2.5 clk = ~clk;
  // Compare one result
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Core reset for 12 cycles, then data out released, float clear and system outputs following function
  task automatic do_reset();
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    check(32'(oe_n), 32'h1, "enable after reset");
    check(32'(flt), 32'h0, "float after reset");
    check(32'(sout), 32'(FUNC), "outputs after reset");
  endtask
  // Main sequence
  initial begin
    logic [31:0] q;
    do_reset();
    tst.bit_cyc(1'b0, 1'b0, q[0]);
    foreach (rows[k]) begin
      tst.scan(1'b1, 3, 32'(rows[k].code), -1, q);
      check(q, 32'(`IR_CAPTURE), "capture-IR value");
      tst.scan(1'b0, rows[k].n, rows[k].pat, -1, q);
      check(q, rows[k].dout, "data scan out");
      check(32'(sout), 32'(rows[k].sys), "system outputs");
      check(32'(flt), 32'(rows[k].flt), "float");
    end
    // Mode-select reset from bypass, then a paused identification scan
    tst.scan(1'b1, 3, 32'(`INS_BYPASS), -1, q);
    repeat (5) tst.bit_cyc(1'b1, 1'b0, q[0]);
    tst.bit_cyc(1'b0, 1'b0, q[0]);
    tst.scan(1'b0, 32, 32'h0, 9, q);
    check(q, IDV, "id after mode reset");
    // Paused instruction scan
    tst.scan(1'b1, 3, 32'(`INS_BYPASS), 0, q);
    check(q, 32'(`IR_CAPTURE), "paused capture-IR");
    tst.scan(1'b0, 8, 32'h96, -1, q);
    check(q, 32'h2C, "bypass after paused scan");
    // Core reset from high-Z, then test reset from high-Z in shift-DR
    tst.scan(1'b1, 3, 32'(`INS_HIGHZ), -1, q);
    check(32'(flt), 32'h1, "float before reset");
    do_reset();
    tst.bit_cyc(1'b0, 1'b0, q[0]);
    tst.scan(1'b1, 3, 32'(`INS_HIGHZ), -1, q);
    check(32'(flt), 32'h1, "float before test reset");
    tst.bit_cyc(1'b1, 1'b0, q[0]);
    repeat (2) tst.bit_cyc(1'b0, 1'b0, q[0]);
    tst.pulse_trst();
    check(32'(oe_n), 32'h1, "enable after test reset");
    check(32'(flt), 32'h0, "float after test reset");
    tst.bit_cyc(1'b0, 1'b0, q[0]);
    tst.scan(1'b0, 32, 32'h0, -1, q);
    check(q, IDV, "id after test reset");
    complete_run();
  end
  // Cut a hung run short
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
